/* File: rtl/l2rda_pkg.sv */
// Purpose: Shared constants, types and helpers for the second-level cache RAM debug access.
// Assumes: Location words are 32 bits wide; cache indices are kept as 17-bit values [16:0].
// Notes:   Index bits [5:0] are never used by the cache and always hold zero.

package l2rda_pkg;

  // ---------------------------------------------------------------------------
  // Location word layout
  // ---------------------------------------------------------------------------
  localparam int         LOC_W          = 32;     // Width of the location operand.
  localparam int         SEL_LSB        = 24;     // Low bit of the RAM selector field.
  localparam logic [7:0] SEL_TAG        = 8'h10;  // Selector of the tag RAM.
  localparam logic [7:0] SEL_DATA       = 8'h11;  // Selector of the data RAM.
  localparam logic [7:0] SEL_VICTIM     = 8'h12;  // Selector of the victim RAM.
  localparam logic [7:0] SEL_TLB        = 8'h18;  // Selector of the translation-buffer RAM.
  localparam int         WAY_SMALL_LSB  = 18;     // Way field low bit, 512KB layouts and TLB.
  localparam int         WAY_LARGE_LSB  = 19;     // Way field low bit, 1MB layouts.
  localparam int         QUAD_LSB       = 4;      // Physical address [5:4] in data layouts.
  localparam logic [4:0] DATA_LARGE_FLIP = 5'h08; // Constant folded into 1MB data index [16:12].

  // ---------------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------------
  localparam int          WAYS       = 8;         // Ways in the cache.
  localparam int          IDX_W      = 17;        // Width of the index vector.
  localparam int          PA_W       = 40;        // Physical address width.
  localparam int          TAG_W      = 56;        // Width of a raw tag RAM entry.
  localparam int          TAG_META_LSB = 35;      // Raw tag: error code .. page attributes.
  localparam int          TAG_PTAG_LSB = 11;      // Raw tag: physical tag, 24 bits.
  localparam int          TAG_N_SMALL  = 34;      // Size constant n for 512KB.
  localparam int          TAG_N_LARGE  = 33;      // Size constant n for 1MB.
  localparam logic [63:0] WORD_RESET = 64'h0;     // Readback words after reset.

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    L2RDA_TGT_TAG,
    L2RDA_TGT_DATA,
    L2RDA_TGT_VICTIM,
    L2RDA_TGT_TLB
  } l2rda_target_type;

  // Index hash that the fill path applies to a physical address.
  function automatic logic [IDX_W-1:0] pa_to_index(input logic [PA_W-1:0] pa,
                                                   input logic            size_large);
    logic [IDX_W-1:0] idx;
    idx = 17'h00000;
    if (size_large) begin
      idx[16:8] = pa[16:8] ^ pa[25:17];
    end else begin
      idx[15:8] = pa[15:8] ^ pa[23:16];
    end
    idx[7:6] = pa[7:6] ^ pa[11:10];
    return idx;
  endfunction

endpackage

/* File: rtl/l2rda_location_decode.sv */
// Purpose: Combinational decode of a debug location word into RAM, way, index and entry.
// Assumes: The cache size input is stable while a word is decoded.
// Notes:   Reserved bits of the word are never looked at.

`timescale 1ns/1ns

module l2rda_location_decode (
  input  wire logic [31:0]                 location_operand,
  input  wire logic                        size_large,
  output logic                             hit,
  output l2rda_pkg::l2rda_target_type      target,
  output logic [2:0]                       way,
  output logic [l2rda_pkg::IDX_W-1:0]      index,
  output logic [7:0]                       entry,
  output logic [1:0]                       quad
);

  // ---------------------------------------------------------------------------
  // Selector and layout decode
  // ---------------------------------------------------------------------------
  logic [7:0] sel;  // RAM selector field of the word.
  logic       is_data; // High for a data RAM location.

  assign sel     = location_operand[l2rda_pkg::SEL_LSB +: 8];
  assign is_data = (sel == l2rda_pkg::SEL_DATA);

  // The XOR terms are undone here so that the RAM sees a plain way and index.
  always_comb begin
    hit    = 1'b0;
    target = l2rda_pkg::L2RDA_TGT_TAG;
    way    = 3'h0;
    index  = 17'h00000;
    entry  = 8'h00;
    quad   = 2'h0;
    case (sel)
      l2rda_pkg::SEL_TAG, l2rda_pkg::SEL_DATA: begin
        hit    = 1'b1;
        target = is_data ? l2rda_pkg::L2RDA_TGT_DATA : l2rda_pkg::L2RDA_TGT_TAG;
        quad   = is_data ? location_operand[l2rda_pkg::QUAD_LSB +: 2] : 2'h0;
        if (!size_large) begin
          way          = location_operand[l2rda_pkg::WAY_SMALL_LSB +: 3];
          index[15:13] = location_operand[15:13];
          index[12:10] = location_operand[12:10] ^ way;
          index[9:8]   = location_operand[9:8];
          index[7:6]   = location_operand[7:6] ^ index[11:10] ^ way[1:0];
        end else begin
          // Only two way bits are carried; the lowest way bit reads as zero.
          way          = {location_operand[l2rda_pkg::WAY_LARGE_LSB +: 2], 1'b0};
          index[16:12] = location_operand[16:12] ^
                         (is_data ? l2rda_pkg::DATA_LARGE_FLIP : 5'h00);
          index[11:9]  = location_operand[11:9] ^ way;
          index[8]     = location_operand[8];
          index[7:6]   = location_operand[7:6] ^ index[11:10] ^ way[2:1];
        end
      end
      l2rda_pkg::SEL_VICTIM: begin
        hit         = 1'b1;
        target      = l2rda_pkg::L2RDA_TGT_VICTIM;
        index[16]   = ~location_operand[16];
        index[15:8] = location_operand[15:8];
        index[7:6]  = location_operand[7:6] ^ index[11:10];
      end
      l2rda_pkg::SEL_TLB: begin
        hit    = 1'b1;
        target = l2rda_pkg::L2RDA_TGT_TLB;
        way    = location_operand[l2rda_pkg::WAY_SMALL_LSB +: 3];
        entry  = location_operand[7:0];
      end
      default: begin
        // Unknown selector: no RAM is named.
        hit = 1'b0;
      end
    endcase
  end

endmodule

/* File: rtl/l2rda_top.sv */
// Purpose: Debug readback of the second-level cache RAMs into three 64-bit words.
// Assumes: Requests and RAM replies come from logic on clk; the RAM answers each read once.
// Notes:   Victim and translation entries are returned raw, without field formatting.

`timescale 1ns/1ns

module l2rda_top (
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  input  wire logic                               ce,
  input  wire logic                               cfg_size_large,
  input  wire logic                               cfg_granule_256,
  input  wire logic                               req_valid,
  input  wire logic [l2rda_pkg::LOC_W-1:0]        location_operand,
  output logic                                    busy,
  output logic                                    done,
  output logic                                    access_fault,
  output logic                                    ram_rd_en,
  output l2rda_pkg::l2rda_target_type             ram_target,
  output logic [2:0]                              ram_way,
  output logic [l2rda_pkg::IDX_W-1:0]             ram_index,
  output logic [7:0]                              ram_entry,
  output logic [1:0]                              ram_quad,
  input  wire logic                               ram_rd_valid,
  input  wire logic [l2rda_pkg::TAG_W-1:0]        ram_tag_entry,
  input  wire logic [127:0]                       ram_data,
  input  wire logic [9:0]                         ram_ecc,
  input  wire logic [1:0]                         ram_poison,
  input  wire logic [3:0]                         ram_mte_tags,
  input  wire logic [l2rda_pkg::PA_W-1:0]         lookup_address,
  output logic [l2rda_pkg::IDX_W-1:0]             lookup_index,
  output logic [63:0]                             ram_readback_word0,
  output logic [63:0]                             ram_readback_word1,
  output logic [63:0]                             ram_readback_word2
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [0:0] {
    L2RDA_IDLE,
    L2RDA_WAIT
  } l2rda_phase_type;

  // Every flip-flop of the block lives in this one record.
  typedef struct packed {
    l2rda_phase_type                phase;        // Access sequencer phase.
    logic                           busy;         // Access in flight.
    logic                           done;         // One-cycle completion pulse.
    logic                           fault;        // Last request had a bad selector.
    logic                           rd_en;        // One-cycle RAM read strobe.
    logic                           size_large;   // Cache size caught at the request.
    logic                           granule_256;  // Protection granule caught at the request.
    l2rda_pkg::l2rda_target_type    target;       // RAM being read.
    logic [2:0]                     way;          // Way of the access.
    logic [l2rda_pkg::IDX_W-1:0]    index;        // Set index of the access.
    logic [7:0]                     entry;        // Translation-buffer entry.
    logic [1:0]                     quad;         // Quad-word within the line.
    logic [l2rda_pkg::IDX_W-1:0]    lookup_index; // Hashed index of the lookup address.
    logic [63:0]                    word0;        // Readback word 0.
    logic [63:0]                    word1;        // Readback word 1.
    logic [63:0]                    word2;        // Readback word 2.
  } l2rda_regs_type;

  l2rda_regs_type regs;       // Registered state.
  l2rda_regs_type next_regs;  // Next state.

  // ---------------------------------------------------------------------------
  // Location decode
  // ---------------------------------------------------------------------------
  logic                           dec_hit;     // Selector names a RAM.
  l2rda_pkg::l2rda_target_type    dec_target;  // Decoded RAM.
  logic [2:0]                     dec_way;     // Decoded way.
  logic [l2rda_pkg::IDX_W-1:0]    dec_index;   // Decoded index.
  logic [7:0]                     dec_entry;   // Decoded entry.
  logic [1:0]                     dec_quad;    // Decoded quad-word.

  // Decoding against the live size input is safe: it is caught in the same cycle.
  l2rda_location_decode u_decode (
    .location_operand (location_operand),
    .size_large       (cfg_size_large),
    .hit              (dec_hit),
    .target           (dec_target),
    .way              (dec_way),
    .index            (dec_index),
    .entry            (dec_entry),
    .quad             (dec_quad)
  );

  // ---------------------------------------------------------------------------
  // Readback formatting
  // ---------------------------------------------------------------------------
  // Places a raw tag entry into word 0; the upper fields move by one bit with size.
  function automatic logic [63:0] format_tag(input logic [l2rda_pkg::TAG_W-1:0] raw,
                                             input logic                        size_large);
    logic [20:0] meta;
    logic [23:0] ptag;
    logic [10:0] low;
    meta = raw[l2rda_pkg::TAG_META_LSB +: 21];
    ptag = raw[l2rda_pkg::TAG_PTAG_LSB +: 24];
    // Bit 9 is reserved and reads zero; coherence and tag state pass as stored.
    low  = {raw[10], 1'b0, raw[8:0]};
    if (size_large) begin
      // n = 33: physical tag [39:17] in [33:11], fields from bit 34 up.
      format_tag = {9'h000, meta, ptag[22:0], low};
    end else begin
      // n = 34: physical tag [39:16] in [34:11], fields from bit 35 up.
      format_tag = {8'h00, meta, ptag, low};
    end
  endfunction

  // Builds data word 2 from the protection code, poison and memory tags.
  function automatic logic [63:0] format_protect(input logic [9:0] ecc,
                                                 input logic [1:0] poison,
                                                 input logic [3:0] tags,
                                                 input logic       granule_256,
                                                 input logic       odd_quad);
    logic [4:0] ecc_half;
    // The second half of a 256-bit code belongs to the upper quad-word.
    ecc_half = odd_quad ? ecc[9:5] : ecc[4:0];
    if (granule_256) begin
      format_protect = {53'h0, ecc_half, poison, tags};
    end else begin
      format_protect = {49'h0, ecc[8:0], poison, tags};
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Requests are taken only in IDLE; one arriving while busy is dropped on purpose,
  // since the core issues the next debug instruction only after done.
  always_comb begin
    next_regs       = regs;
    next_regs.done  = 1'b0;
    next_regs.rd_en = 1'b0;
    // The fill-path hash runs every cycle, independent of debug accesses.
    next_regs.lookup_index = l2rda_pkg::pa_to_index(lookup_address,
                                                    cfg_size_large);
    case (regs.phase)
      L2RDA_IDLE: begin
        if (req_valid) begin
          next_regs.size_large  = cfg_size_large;
          next_regs.granule_256 = cfg_granule_256;
          if (dec_hit) begin
            next_regs.rd_en  = 1'b1;
            next_regs.busy   = 1'b1;
            next_regs.fault  = 1'b0;
            next_regs.target = dec_target;
            next_regs.way    = dec_way;
            next_regs.index  = dec_index;
            next_regs.entry  = dec_entry;
            next_regs.quad   = dec_quad;
            next_regs.phase  = L2RDA_WAIT;
          end else begin
            // No RAM is read; the words keep the last result.
            next_regs.fault = 1'b1;
            next_regs.done  = 1'b1;
          end
        end
      end
      L2RDA_WAIT: begin
        if (ram_rd_valid) begin
          next_regs.busy  = 1'b0;
          next_regs.done  = 1'b1;
          next_regs.phase = L2RDA_IDLE;
          case (regs.target)
            l2rda_pkg::L2RDA_TGT_TAG: begin
              next_regs.word0 = format_tag(ram_tag_entry, regs.size_large);
              next_regs.word1 = 64'h0;
              next_regs.word2 = 64'h0;
            end
            l2rda_pkg::L2RDA_TGT_DATA: begin
              next_regs.word0 = ram_data[63:0];
              next_regs.word1 = ram_data[127:64];
              next_regs.word2 = format_protect(ram_ecc, ram_poison, ram_mte_tags,
                                               regs.granule_256, regs.quad[0]);
            end
            l2rda_pkg::L2RDA_TGT_VICTIM: begin
              // Victim entries fit one word and are passed unformatted.
              next_regs.word0 = ram_data[63:0];
              next_regs.word1 = 64'h0;
              next_regs.word2 = 64'h0;
            end
            default: begin
              // Translation entries are passed unformatted across two words.
              next_regs.word0 = ram_data[63:0];
              next_regs.word1 = ram_data[127:64];
              next_regs.word2 = 64'h0;
            end
          endcase
        end
      end
      default: begin
        // Unreachable encoding: return to a clean idle.
        next_regs.phase = L2RDA_IDLE;
        next_regs.busy  = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Clock enable low freezes every bit, pulses included.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regs.phase        <= L2RDA_IDLE;
      regs.busy         <= 1'b0;
      regs.done         <= 1'b0;
      regs.fault        <= 1'b0;
      regs.rd_en        <= 1'b0;
      regs.size_large   <= 1'b0;
      regs.granule_256  <= 1'b0;
      regs.target       <= l2rda_pkg::L2RDA_TGT_TAG;
      regs.way          <= 3'h0;
      regs.index        <= 17'h00000;
      regs.entry        <= 8'h00;
      regs.quad         <= 2'h0;
      regs.lookup_index <= 17'h00000;
      regs.word0        <= l2rda_pkg::WORD_RESET;
      regs.word1        <= l2rda_pkg::WORD_RESET;
      regs.word2        <= l2rda_pkg::WORD_RESET;
    end else if (ce) begin
      regs <= next_regs;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // All outputs are plain flip-flop taps.
  assign busy               = regs.busy;
  assign done               = regs.done;
  assign access_fault       = regs.fault;
  assign ram_rd_en          = regs.rd_en;
  assign ram_target         = regs.target;
  assign ram_way            = regs.way;
  assign ram_index          = regs.index;
  assign ram_entry          = regs.entry;
  assign ram_quad           = regs.quad;
  assign lookup_index       = regs.lookup_index;
  assign ram_readback_word0 = regs.word0;
  assign ram_readback_word1 = regs.word1;
  assign ram_readback_word2 = regs.word2;

endmodule

/* File: verif/l2rda_ram_model.sv */
// Purpose: Behavioural cache RAM that answers the debug readback block.
// Assumes: One read is outstanding at a time; lat sets the reply delay in cycles.
// Notes:   Reply lines carry the inverse pattern outside the reply cycle.
`timescale 1ns/1ns
module l2rda_ram_model (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         rd_en,
  input  wire logic [2:0]   way,
  input  wire logic [16:0]  index,
  input  wire logic [3:0]   lat,
  output logic              rd_valid,
  output logic [55:0]       tag_entry,
  output logic [127:0]      data,
  output logic [9:0]        ecc,
  output logic [1:0]        poison,
  output logic [3:0]        tags
);
  logic [3:0]  cnt;  // Cycles left before a delayed reply.
  logic [55:0] t;    // Stored tag; bit 9 kept clear because it reads as reserved.
  logic [31:0] d;    // Data pattern built from the address.
  // Count down a pending reply; a zero delay answers in the strobe cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cnt <= 4'h0;
    else if (rd_en)
      cnt <= lat;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end
  assign rd_valid = (rd_en && lat == 4'h0) || cnt == 4'h1;
  // Contents follow way and index, so a wrong address shows in the words.
  assign t = {4'hC, index, way, index, way, 2'h3, 1'h0, 9'h1A5};
  assign d = {12'h0, way, index};
  // Outside the reply the lines are inverted, so stale values never match.
  always_comb begin
    tag_entry = rd_valid ? t : ~t;
    data = {d, ~d, d ^ 32'h5A5A5A5A, d ^ 32'h0000FFFF} ^ {128{~rd_valid}};
    ecc = rd_valid ? index[15:6] : ~index[15:6];
    poison = rd_valid ? way[1:0] : ~way[1:0];
    tags = rd_valid ? index[9:6] ^ 4'h9 : index[9:6] ^ 4'h6;
  end
endmodule

/* File: verif/l2rda_top_asserts.sv */
// Purpose: Timing and decode properties of the RAM debug readback block.
// Assumes: One clock domain; ce is high whenever a request is taken.
// Notes:   Sees only the ports of the top module.
`timescale 1ns/1ns
module l2rda_top_asserts (
  input wire logic                          clk,
  input wire logic                          rst_n,
  input wire logic                          ce,
  input wire logic                          cfg_size_large,
  input wire logic                          req_valid,
  input wire logic [31:0]                   location_operand,
  input wire logic                          busy,
  input wire logic                          done,
  input wire logic                          access_fault,
  input wire logic                          ram_rd_en,
  input wire l2rda_pkg::l2rda_target_type   ram_target,
  input wire logic [2:0]                    ram_way,
  input wire logic [16:0]                   ram_index,
  input wire logic [7:0]                    ram_entry,
  input wire logic                          ram_rd_valid,
  input wire logic [63:0]                   ram_readback_word1,
  input wire logic [63:0]                   ram_readback_word2
);
  logic [7:0] sel;   // Selector field of the word.
  logic       take;  // A request is accepted at this edge.
  logic       good;  // The selector names one of the RAMs.
  assign sel = location_operand[31:24];
  assign take = ce && req_valid && !busy;
  assign good = sel == 8'h10 || sel == 8'h11 || sel == 8'h12 || sel == 8'h18;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  good_read_a: assert property (take && good |=> ram_rd_en && busy && !access_fault)
    else $error("accepted read gave no strobe");
  rd_pulse_a: assert property (ram_rd_en && ce |=> !ram_rd_en)
    else $error("read strobe longer than one cycle");
  bad_sel_a: assert property (take && !good |=> done && access_fault && !ram_rd_en)
    else $error("unknown selector not refused");
  reply_done_a: assert property (busy && ram_rd_valid && ce |=> done && !busy)
    else $error("reply did not complete access");
  tag_zero_a: assert property (done && !access_fault &&
    ram_target == l2rda_pkg::L2RDA_TGT_TAG |-> ram_readback_word1 == 64'h0 &&
    ram_readback_word2 == 64'h0) else $error("tag words 1 and 2 not zero");
  data_pad_a: assert property (done && !access_fault &&
    ram_target == l2rda_pkg::L2RDA_TGT_DATA |-> ram_readback_word2[63:15] == 49'h0)
    else $error("data word 2 upper bits not zero");
  tlb_field_a: assert property (take && sel == 8'h18 |=>
    ram_entry == $past(location_operand[7:0]) && ram_way == $past(location_operand[20:18]))
    else $error("translation way or entry wrong");
  victim_idx_a: assert property (take && sel == 8'h12 |=> ram_index[16:6] ==
    {!$past(location_operand[16]), $past(location_operand[15:6]) ^
    {8'h0, $past(location_operand[11:10])}}) else $error("victim index wrong");
  small_way_a: assert property (take && sel == 8'h10 && !cfg_size_large |=>
    ram_way == $past(location_operand[20:18])) else $error("tag way wrong");
endmodule
bind l2rda_top l2rda_top_asserts u_l2rda_top_asserts (
  .clk, .rst_n, .ce, .cfg_size_large, .req_valid, .location_operand, .busy, .done,
  .access_fault, .ram_rd_en, .ram_target, .ram_way, .ram_index, .ram_entry, .ram_rd_valid,
  .ram_readback_word1, .ram_readback_word2);

/* File: verif/l2rda_top_tb.sv */
// Purpose: Self-checking bench for the RAM debug readback block.
// Assumes: The RAM model answers every strobe.
// Notes:   Expected words are built from the reply captured at the RAM pins.
`timescale 1ns/1ns
module l2rda_top_tb;
  logic         clk = 1'h0, rst_n = 1'h0, lg = 1'h0, gr = 1'h0, rq = 1'h0, ce = 1'h1;
  logic [31:0]  loc = 32'h0;  // Location word.
  logic [39:0]  pa = 40'h0;   // Lookup address.
  logic [3:0]   lat = 4'h0;   // RAM reply delay.
  logic         busy, done, fault, rd_en, rv;
  logic [2:0]   way;
  logic [16:0]  idx, lidx;
  logic [7:0]   ent;
  logic [1:0]   quad, po, cp;
  logic [63:0]  w0, w1, w2;
  logic [55:0]  te, ct;
  logic [127:0] dt, cd;
  logic [9:0]   ec, cec;
  logic [3:0]   mt, cm;
  int           bad_count = 0, n_tests = 0, rd_cnt = 0;
  l2rda_pkg::l2rda_target_type tgt;
  always #50 clk = ~clk;
  l2rda_top u_l2rda_top (.clk(clk), .rst_n(rst_n), .ce(ce), .cfg_size_large(lg),
    .cfg_granule_256(gr), .req_valid(rq), .location_operand(loc), .busy(busy), .done(done),
    .access_fault(fault), .ram_rd_en(rd_en), .ram_target(tgt), .ram_way(way),
    .ram_index(idx), .ram_entry(ent), .ram_quad(quad), .ram_rd_valid(rv),
    .ram_tag_entry(te), .ram_data(dt), .ram_ecc(ec), .ram_poison(po), .ram_mte_tags(mt),
    .lookup_address(pa), .lookup_index(lidx), .ram_readback_word0(w0),
    .ram_readback_word1(w1), .ram_readback_word2(w2));
  l2rda_ram_model u_l2rda_ram_model (.clk(clk), .rst_n(rst_n), .rd_en(rd_en), .way(way),
    .index(idx), .lat(lat), .rd_valid(rv), .tag_entry(te), .data(dt), .ecc(ec),
    .poison(po), .tags(mt));
  // Keep the last reply and count strobes, since refused requests must not read.
  always @(posedge clk) begin
    if (rv === 1'h1) {ct, cd, cec, cp, cm} = {te, dt, ec, po, mt};
    if (rd_en === 1'h1) rd_cnt++;
  end
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Builds a location word with every reserved bit set, to show they are ignored.
  function automatic logic [31:0] enc(input logic [7:0] s, input logic l,
    input logic [2:0] w, input logic [16:0] i, input logic [1:0] q);
    logic [4:0] f;
    f = (s == 8'h11) ? 5'h08 : 5'h00;
    if (l) return {s, 3'h7, w[2:1], 2'h3, i[16:12] ^ f, i[11:9] ^ w, i[8],
      i[7:6] ^ i[11:10] ^ w[2:1], q, 4'hF};
    return {s, 3'h7, w, 2'h3, i[15:13], i[12:10] ^ w, i[9:8], i[7:6] ^ i[11:10] ^ w[1:0], q, 4'hF};
  endfunction
  // One request, then wait a bounded time for the completion pulse.
  task automatic go(input logic [31:0] l, input logic sz, input logic g);
    int k;
    @(posedge clk);
    {rq, loc, lg, gr} <= {1'h1, l, sz, g};
    @(posedge clk);
    rq <= 1'h0;
    #1;
    for (k = 0; k < 20 && done !== 1'h1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("done", 64'(done), 64'h1);
  endtask
  task automatic t_tag(input logic l, input logic [2:0] w, input logic [16:0] i);
    go(enc(8'h10, l, w, i, 2'h3), l, 1'h0);
    chk("tag way", 64'(way), 64'(w));
    chk("tag index", 64'(idx), 64'(i));
    chk("tag word0", w0, l ? {9'h0, ct[55:35], ct[33:0]} : {8'h0, ct});
    chk("tag word1", w1 | w2, 64'h0);
  endtask
  task automatic t_data(input logic l, input logic g, input logic [2:0] w,
    input logic [16:0] i, input logic [1:0] q);
    go(enc(8'h11, l, w, i, q), l, g);
    chk("data index", 64'(idx), 64'(i));
    chk("data quad", 64'(quad), 64'(q));
    chk("data word0", w0, cd[63:0]);
    chk("data word1", w1, cd[127:64]);
    chk("data word2", w2, g ? {53'h0, q[0] ? cec[9:5] : cec[4:0], cp, cm}
      : {49'h0, cec[8:0], cp, cm});
  endtask
  task automatic t_bad;
    logic [63:0] s;
    int r;
    s = w0;
    r = rd_cnt;
    go(32'h13000000, 1'h0, 1'h0);
    chk("fault", 64'(fault), 64'h1);
    chk("refused reads", 64'(rd_cnt - r), 64'h0);
    chk("word0 kept", w0, s);
  endtask
  task automatic t_tlb;
    go({8'h18, 3'h7, 3'h3, 10'h3FF, 8'hFF}, 1'h1, 1'h0);
    chk("fault cleared", 64'(fault), 64'h0);
    chk("tlb target", 64'(tgt), 64'(l2rda_pkg::L2RDA_TGT_TLB));
    chk("tlb way entry", 64'({way, ent}), 64'h3FF);
  endtask
  // A request offered while the clock enable is low must leave the block frozen.
  task automatic t_ce;
    @(posedge clk);
    {ce, rq, loc} <= {1'h0, 1'h1, 32'h10000000};
    repeat (3) @(posedge clk);
    ce <= 1'h1;
    rq <= 1'h0;
    #1;
    chk("frozen", 64'({busy, done, rd_en}), 64'h0);
  endtask
  task automatic t_vic(input logic [16:0] i);
    go({8'h12, 7'h7F, ~i[16], i[15:8], i[7:6] ^ i[11:10], 6'h3F}, 1'h0, 1'h0);
    chk("victim index", 64'(idx), 64'(i));
  endtask
  task automatic t_look(input logic l, input logic [39:0] a);
    @(posedge clk);
    {pa, lg} <= {a, l};
    repeat (2) @(posedge clk);
    #1;
    chk("lookup", 64'(lidx), l ? 64'({a[16:8] ^ a[25:17], a[7:6] ^ a[11:10], 6'h0})
      : 64'({1'h0, a[15:8] ^ a[23:16], a[7:6] ^ a[11:10], 6'h0}));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence; requests follow each other straight after each done pulse.
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    t_tag(1'h0, 3'h5, 17'h0ABC0);
    t_tag(1'h1, 3'h6, 17'h1F3C0);
    t_data(1'h0, 1'h0, 3'h7, 17'h0FFC0, 2'h2);
    t_data(1'h1, 1'h1, 3'h2, 17'h155C0, 2'h1);
    lat <= 4'h3;
    t_data(1'h0, 1'h1, 3'h0, 17'h0A040, 2'h0);
    t_bad;
    t_tlb;
    t_vic(17'h1A4C0);
    t_ce;
    t_look(1'h0, 40'h00_00C3_A5C0);
    t_look(1'h1, 40'h00_03F1_96C0);
    test_done;
  end
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #1000000;
    bad_count++;
    test_done;
  end
endmodule
